/* logic/brr_cfg.svh */
// Fixed geometry, field widths and timing counts of the Bayer row readout.
// Assumes it is included by bare name by every file that needs a figure.
`ifndef BRR_CFG_SVH
`define BRR_CFG_SVH

`define BRR_PIX_W 10
`define BRR_PATHS 4
`define BRR_ARRAY_ROWS 12'h09a0
`define BRR_ARRAY_COLS 12'h0cd0
`define BRR_ACTIVE_ROWS 12'h0990
`define BRR_ACTIVE_COLS 12'h0cc0
`define BRR_COL_GROUPS_LAST 10'h333
`define BRR_FIRST_ACT_GRP 10'h002
`define BRR_LAST_ACT_GRP 10'h331
`define BRR_FIRST_ACT_ROW 12'h008
`define BRR_LAST_ACT_ROW 12'h0997
`define BRR_DARK_ROWS 12'h008
`define BRR_DARK_COUNT 13'h1000
`define BRR_DARK_STEP 13'h0002
`define BRR_GAIN_W 8
`define BRR_GAIN_FRAC 5
`define BRR_GAIN_UNITY 8'h20
`define BRR_PIX_MAX 10'h3ff
`define BRR_SER_LAST 4'h9
`define BRR_HBLANK_LAST 5'h0f
`define BRR_EXP_MIN 12'h001

`endif

/* logic/brr_pkg.sv */
// Types shared by the Bayer row readout files.
// Assumes the geometry figures come from brr_cfg.svh.
package brr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LINE,
    ST_REQ,
    ST_WAIT,
    ST_SHIFT,
    ST_BLANK
  } brr_state_t;

  typedef enum logic [1:0] {
    BRR_RED,
    BRR_GREEN_R,
    BRR_GREEN_B,
    BRR_BLUE
  } brr_colour_t;

endpackage

/* logic/brr_lane.sv */
// One digital data path: black-level removal, colour gain, pedestal and
// a ten-bit serialiser that drives one output lane.
// Assumes load and shift come from the readout sequencer on the same clock.
`timescale 1ns/1ps
`include "brr_cfg.svh"
module brr_lane
  import brr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Raw sample and the settings of its colour
  input wire logic [`BRR_PIX_W-1:0] raw,
  input wire logic [`BRR_PIX_W-1:0] black,
  input wire logic [`BRR_GAIN_W-1:0] gain,
  input wire logic [`BRR_PIX_W-1:0] pedestal,
  // Sequencer strobes
  input wire logic load,
  input wire logic shift,
  // Serial lane
  output logic ser_bit
);

  logic [`BRR_PIX_W:0] diff;
  logic [`BRR_PIX_W-1:0] level;
  logic [`BRR_PIX_W+`BRR_GAIN_W-1:0] product;
  logic [13:0] sum;
  logic [`BRR_PIX_W-1:0] corrected;
  logic [`BRR_PIX_W-1:0] shreg;

  // Samples below the measured black level clip to zero before gain.
  assign diff = {1'b0, raw} - {1'b0, black};
  assign level = diff[`BRR_PIX_W] ? '0 : diff[`BRR_PIX_W-1:0];
  // Gain is unsigned with five fraction bits, so 8'h20 is unity.
  assign product = level * gain;
  assign sum = {1'b0, product[`BRR_PIX_W+`BRR_GAIN_W-1:`BRR_GAIN_FRAC]}
    + {4'h0, pedestal};
  // Saturate rather than wrap; a wrap would turn highlights black.
  assign corrected = (|sum[13:`BRR_PIX_W]) ? `BRR_PIX_MAX : sum[`BRR_PIX_W-1:0];

  always_ff @(posedge mclk) begin
    if (reset) begin
      shreg <= '0;
    end else if (load) begin
      shreg <= corrected;
    end else if (shift) begin
      shreg <= {shreg[`BRR_PIX_W-2:0], 1'b0};
    end
  end

  // The word leaves most significant bit first.
  assign ser_bit = shreg[`BRR_PIX_W-1];

  property p_black_clip;
    @(posedge mclk) disable iff (reset)
    (load && raw <= black) |=> (shreg == $past(pedestal));
  endproperty
  a_black_clip: assert property (p_black_clip)
    else $error("sample at or below black level did not reduce to the pedestal");

endmodule

/* logic/brr_readout.sv */
// Row-sequential readout for a Bayer sensor: row reset and read sequencing,
// dark-row black level, four corrected data paths and four serial lanes.
// Assumes the array, converter and settings source all run on mclk.
//
// Functional notes
// - Rows are handled one at a time: each row is reset, and that same row is read later.
// - A row integrates from its reset to its read, and exposure changes only by that gap.
// - Every pixel gives one 10-bit sample on each readout.
// - Even rows carry green and red sites, odd rows carry blue and green sites.
// - Even columns carry red or green sites, odd columns carry blue or green sites.
// - The active image is 3264 by 2448 inside a full 3280 by 2464 array.
// - Shielded pixels feed the offset correction that sets the black level.
// - Converted samples pass a digital chain with corrections and programmable gain.
// - The digital chain is four parallel data paths, one per core column path.
// - Offset and gain are set separately for each Bayer colour.
// - Exposure, gain, pedestal and flash come from host-programmed registers; frame size is fixed.
// - Image data leaves only over the four serial lanes, with no parallel port.
// - A flash output is timed so an external light can match the exposure.
`timescale 1ns/1ps
`include "brr_cfg.svh"
module brr_readout
  import brr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Settings held by the host-facing register block
  input wire logic stream_on,
  input wire logic [11:0] exposure_rows,
  input wire logic flash_enable,
  input wire logic [3:0][`BRR_GAIN_W-1:0] colour_gain,
  input wire logic [3:0][`BRR_PIX_W-1:0] colour_pedestal,
  // Row control towards the pixel array
  output logic row_reset_pulse,
  output logic [11:0] row_reset_addr,
  output logic row_read_pulse,
  output logic [11:0] row_read_addr,
  // Column converter, four columns per group
  output logic sample_req,
  output logic [9:0] sample_grp,
  input wire logic adc_valid,
  input wire logic [`BRR_PATHS-1:0][`BRR_PIX_W-1:0] adc_data,
  // Serial output lanes
  output logic [`BRR_PATHS-1:0] lane_bit,
  output logic lane_valid,
  output logic lane_sof,
  output logic lane_sol,
  // Flash and status
  output logic flash_out,
  output logic frame_busy,
  output logic [15:0] frame_count,
  output logic [3:0][`BRR_PIX_W-1:0] black_level
);

  brr_state_t state;
  brr_state_t next_state;
  logic [12:0] line;
  logic [11:0] rd_row;
  logic [11:0] exp_lat;
  logic [9:0] col_grp;
  logic [3:0] shift_cnt;
  logic [4:0] blank_cnt;
  logic sof_pending;
  logic sol_pending;

  logic start;
  logic resetting;
  logic reading;
  logic emit_row;
  logic emit_col;
  logic load;
  logic skip;
  logic shift_done;
  logic blank_done;
  logic line_end;
  logic last_grp;
  logic frame_end;
  logic grp_step;
  logic dark_cap;
  logic dark_done;
  logic [12:0] last_line;
  logic [11:0] exp_eff;

  // Exposure is caught once per frame, so a host write mid-frame cannot
  // tear the reset-to-read spacing of rows already integrating.
  assign exp_eff = (exposure_rows == 12'h000) ? `BRR_EXP_MIN : exposure_rows;
  assign start = (state == ST_IDLE) && stream_on;

  // Line L resets row L and reads row L minus the exposure in lines.
  assign resetting = line < {1'b0, `BRR_ARRAY_ROWS};
  assign reading = (line >= {1'b0, exp_lat}) && (rd_row < `BRR_ARRAY_ROWS);
  assign last_line = {1'b0, `BRR_ARRAY_ROWS} - 13'h0001 + {1'b0, exp_lat};

  // Border rows and columns are read but not sent; only the first eight rows feed the black level.
  assign emit_row = (rd_row >= `BRR_FIRST_ACT_ROW) && (rd_row <= `BRR_LAST_ACT_ROW);
  assign emit_col = (col_grp >= `BRR_FIRST_ACT_GRP) && (col_grp <= `BRR_LAST_ACT_GRP);
  assign load = (state == ST_WAIT) && adc_valid && emit_row && emit_col;
  assign skip = (state == ST_WAIT) && adc_valid && !(emit_row && emit_col);

  assign shift_done = shift_cnt == `BRR_SER_LAST;
  assign blank_done = blank_cnt == `BRR_HBLANK_LAST;
  assign last_grp = col_grp == `BRR_COL_GROUPS_LAST;
  assign line_end = (state == ST_BLANK) && blank_done;
  assign frame_end = line_end && (line == last_line);
  assign grp_step = ((skip || ((state == ST_SHIFT) && shift_done)) && !last_grp);

  assign dark_cap = (state == ST_WAIT) && adc_valid && (rd_row < `BRR_DARK_ROWS);
  assign dark_done = line_end && reading && (rd_row == `BRR_DARK_ROWS - 12'h001);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (stream_on) begin
          next_state = ST_LINE;
        end
      end
      ST_LINE: begin
        next_state = reading ? ST_REQ : ST_BLANK;
      end
      ST_REQ: begin
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (load) begin
          next_state = ST_SHIFT;
        end else if (skip) begin
          next_state = last_grp ? ST_BLANK : ST_REQ;
        end
      end
      ST_SHIFT: begin
        if (shift_done) begin
          next_state = last_grp ? ST_BLANK : ST_REQ;
        end
      end
      ST_BLANK: begin
        if (blank_done) begin
          next_state = (line == last_line) ? ST_IDLE : ST_LINE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      line <= '0;
      rd_row <= '0;
      exp_lat <= `BRR_EXP_MIN;
    end else if (start) begin
      line <= '0;
      rd_row <= '0;
      exp_lat <= exp_eff;
    end else if (line_end) begin
      line <= line + 13'h0001;
      rd_row <= reading ? rd_row + 12'h001 : rd_row;
    end
  end

  // Column groups advance strictly upward within a row.
  always_ff @(posedge mclk) begin
    if (reset || state == ST_LINE) begin
      col_grp <= '0;
    end else if (grp_step) begin
      col_grp <= col_grp + 10'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || load) begin
      shift_cnt <= '0;
    end else if (state == ST_SHIFT) begin
      shift_cnt <= shift_cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || state != ST_BLANK) begin
      blank_cnt <= '0;
    end else begin
      blank_cnt <= blank_cnt + 5'h01;
    end
  end

  // Start markers sit on the first bit of the first word of a frame or row.
  always_ff @(posedge mclk) begin
    if (reset) begin
      sof_pending <= 1'b0;
      sol_pending <= 1'b0;
      lane_sof <= 1'b0;
      lane_sol <= 1'b0;
    end else begin
      sof_pending <= start || (sof_pending && !load);
      sol_pending <= (state == ST_LINE) || (sol_pending && !load);
      lane_sof <= load && sof_pending;
      lane_sol <= load && sol_pending;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_count <= '0;
    end else if (frame_end) begin
      frame_count <= frame_count + 16'h0001;
    end
  end

  // Flash spans the first active row's reset to the last active row's read,
  // which covers every active row's integration whatever the exposure.
  always_ff @(posedge mclk) begin
    if (reset || !flash_enable) begin
      flash_out <= 1'b0;
    end else if (row_reset_pulse && row_reset_addr == `BRR_FIRST_ACT_ROW) begin
      flash_out <= 1'b1;
    end else if (line_end && reading && rd_row == `BRR_LAST_ACT_ROW) begin
      flash_out <= 1'b0;
    end
  end

  assign row_reset_pulse = (state == ST_LINE) && resetting;
  assign row_reset_addr = line[11:0];
  assign row_read_pulse = (state == ST_LINE) && reading;
  assign row_read_addr = rd_row;
  assign sample_req = state == ST_REQ;
  assign sample_grp = col_grp;
  assign lane_valid = state == ST_SHIFT;
  assign frame_busy = state != ST_IDLE;

  // Colour index c is {row parity, column parity}; paths k and k+2 share a
  // column parity, so each colour takes two samples per dark group. The
  // average uses only the first 4096 samples so the divide is a shift.
  for (genvar c = 0; c < 4; c++) begin : g_dark
    logic [`BRR_PIX_W:0] pair;
    logic take;
    logic [21:0] sum;
    logic [12:0] cnt;
    logic [`BRR_PIX_W-1:0] level;

    assign pair = {1'b0, adc_data[c % 2]} + {1'b0, adc_data[c % 2 + 2]};
    assign take = dark_cap && (rd_row[0] == 1'(c / 2)) && (cnt < `BRR_DARK_COUNT);

    always_ff @(posedge mclk) begin
      if (reset || start) begin
        sum <= '0;
        cnt <= '0;
      end else if (take) begin
        sum <= sum + {11'h000, pair};
        cnt <= cnt + `BRR_DARK_STEP;
      end
    end

    always_ff @(posedge mclk) begin
      if (reset) begin
        level <= '0;
      end else if (dark_done) begin
        level <= sum[21:12];
      end
    end

    assign black_level[c] = level;
  end

  // Each path is one column parity, so its colour follows row parity.
  for (genvar k = 0; k < `BRR_PATHS; k++) begin : g_path
    logic [1:0] colour;

    assign colour = {rd_row[0], 1'(k % 2)};
    // Per-colour black, gain and pedestal select for this path.
    brr_lane u_lane (
      .mclk(mclk),
      .reset(reset),
      .raw(adc_data[k]),
      .black(black_level[colour]),
      .gain(colour_gain[colour]),
      .pedestal(colour_pedestal[colour]),
      .load(load),
      .shift(lane_valid),
      .ser_bit(lane_bit[k])
    );
  end

  property p_read_gap;
    @(posedge mclk) disable iff (reset)
    row_read_pulse |-> ((line - {1'b0, exp_lat}) == {1'b0, row_read_addr});
  endproperty
  a_read_gap: assert property (p_read_gap)
    else $error("row read does not trail its reset by the exposure");

  property p_row_spacing;
    @(posedge mclk) disable iff (reset)
    row_read_pulse |=> (!row_read_pulse)[*8];
  endproperty
  a_row_spacing: assert property (p_row_spacing)
    else $error("two row reads too close together");

  // Run length of the current word; a ten-cycle repetition would be costly to unroll.
  logic [3:0] valid_run;
  always_ff @(posedge mclk) begin
    if (reset || !lane_valid) begin
      valid_run <= '0;
    end else begin
      valid_run <= valid_run + 4'h1;
    end
  end

  property p_word_len;
    @(posedge mclk) disable iff (reset)
    lane_valid |-> (valid_run < 4'ha);
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("serial word is longer than ten bits");

  property p_word_end;
    @(posedge mclk) disable iff (reset)
    $fell(lane_valid) |-> (valid_run == 4'ha);
  endproperty
  a_word_end: assert property (p_word_end)
    else $error("serial word ended before ten bits");

  property p_lane_quiet;
    @(posedge mclk) disable iff (reset)
    !lane_valid |-> (lane_bit == 4'h0);
  endproperty
  a_lane_quiet: assert property (p_lane_quiet)
    else $error("lane toggles outside a word");

  property p_emit_window;
    @(posedge mclk) disable iff (reset)
    load |-> (rd_row >= 12'h008 && rd_row <= 12'h0997
      && col_grp >= 10'h002 && col_grp <= 10'h331);
  endproperty
  a_emit_window: assert property (p_emit_window)
    else $error("border pixel sent on the lanes");

  property p_black_latch;
    @(posedge mclk) disable iff (reset)
    (black_level != $past(black_level)) |-> $past(dark_done);
  endproperty
  a_black_latch: assert property (p_black_latch)
    else $error("black level changed outside the dark-row close");

  property p_flash_rise;
    @(posedge mclk) disable iff (reset)
    $rose(flash_out) |-> ($past(row_reset_pulse) && $past(row_reset_addr) == 12'h008);
  endproperty
  a_flash_rise: assert property (p_flash_rise)
    else $error("flash rose away from the first active row reset");

  property p_col_order;
    @(posedge mclk) disable iff (reset)
    (sample_req && sample_grp != 10'h000) |-> (sample_grp == $past(sample_grp) + 10'h001);
  endproperty
  a_col_order: assert property (p_col_order)
    else $error("column groups out of order");

  property p_exp_hold;
    @(posedge mclk) disable iff (reset)
    (frame_busy && $past(frame_busy)) |-> (exp_lat == $past(exp_lat));
  endproperty
  a_exp_hold: assert property (p_exp_hold)
    else $error("exposure changed inside a frame");

endmodule

/* verif/brr_adc_model.sv */
// Behavioural column converter standing in for the array and its converters.
// Assumes sample_req, sample_grp and row_read_addr change on the rising edge of mclk.
`timescale 1ns/1ps
`include "brr_cfg.svh"
module brr_adc_model (
  // Clock
  input wire logic mclk,
  // Request from the sequencer
  input wire logic sample_req,
  input wire logic [9:0] sample_grp,
  input wire logic [11:0] row_read_addr,
  // Answer pace, high answers three cycles after the request
  input wire logic slow,
  // Converter answer
  output logic adc_valid,
  output logic [`BRR_PATHS-1:0][`BRR_PIX_W-1:0] adc_data
);
  logic [11:0] row;
  logic [9:0] grp;
  logic [`BRR_PATHS-1:0][`BRR_PIX_W-1:0] next_data;
  int cnt = 0;

  // Dark rows give one flat level per colour so that the averaged black level is exact.
  function automatic logic [9:0] pix(input logic [11:0] r, input logic [9:0] g,
                                     input logic [1:0] k);
    if (r < `BRR_DARK_ROWS) return 10'h040 + {4'h0, r[0], k[0], 4'h0};
    return {g[7:0], k} ^ 10'h200;
  endfunction

  initial begin
    adc_valid = 1'b0;
    adc_data = '0;
  end

  // Data changes every idle cycle, so a sample taken outside the pulse is visibly wrong.
  always @(posedge mclk) begin
    #1;
    if (cnt == 1) begin
      for (int k = 0; k < 4; k++) next_data[k] = pix(row, grp, 2'(k));
    end else begin
      next_data = ~adc_data;
    end
    adc_valid = (cnt == 1);
    adc_data = next_data;
    if (cnt > 0) cnt--;
    if (sample_req) begin
      row = row_read_addr;
      grp = sample_grp;
      cnt = slow ? 3 : 1;
    end
  end
endmodule

/* verif/tb.sv */
// Self-checking bench for the Bayer row readout: frame start, dark rows,
// black level, flash timing and every word of the first active row.
// Assumes brr_adc_model answers each sample request of the sequencer.
`timescale 1ns/1ps
`include "brr_cfg.svh"
module tb;
  import brr_pkg::*;
  localparam int EXP = 3;
  logic mclk, reset, stream_on, flash_enable, slow;
  logic [11:0] exposure_rows, row_reset_addr, row_read_addr;
  logic [3:0][7:0] colour_gain;
  logic [3:0][9:0] colour_pedestal, adc_data, black_level, sh;
  logic row_reset_pulse, row_read_pulse, sample_req, adc_valid;
  logic [9:0] sample_grp;
  logic [3:0] lane_bit;
  logic lane_valid, lane_sof, lane_sol, flash_out, frame_busy;
  logic [15:0] frame_count;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int nbit = 0;
  int nword = 0;
  int row_words = 0;
  int first_grp = 0;
  int last_grp = 0;
  int nxt_grp = 0;
  bit mon_on = 1'b0;

  brr_readout uut (.mclk, .reset, .stream_on, .exposure_rows, .flash_enable, .colour_gain,
    .colour_pedestal, .row_reset_pulse, .row_reset_addr, .row_read_pulse, .row_read_addr,
    .sample_req, .sample_grp, .adc_valid, .adc_data, .lane_bit, .lane_valid, .lane_sof,
    .lane_sol, .flash_out, .frame_busy, .frame_count, .black_level);

  brr_adc_model adc (.mclk, .sample_req, .sample_grp, .row_read_addr, .slow, .adc_valid,
    .adc_data);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Worked out from the stimulus: dark level 0x40 plus 0x10 per colour is the black level.
  function automatic logic [9:0] expw(input logic [11:0] r, input logic [9:0] g, input int k);
    int c, d, p;
    c = 2 * r[0] + k % 2;
    d = int'({g[7:0], 2'(k)} ^ 10'h200) - (64 + 16 * c);
    if (d < 0) d = 0;
    p = ((d * colour_gain[c]) >> 5) + colour_pedestal[c];
    return (p > 1023) ? 10'h3ff : 10'(p);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  // Lane monitor, sampled late in the cycle so both partners have settled.
  always @(posedge mclk) begin
    #2;
    cycles++;
    if (cycles > 60000) begin
      n_mismatch++;
      finish_test();
    end
    if (mon_on) begin
      if (row_read_pulse) begin
        chk(row_read_addr, 12'(row_reset_addr - EXP));
        row_words = nword;
        nword = 0;
        nxt_grp = 0;
      end
      if (sample_req) begin
        chk(sample_grp, 16'(nxt_grp));
        nxt_grp = sample_grp + 1;
      end
      if (lane_valid) begin
        if (nbit == 0) begin
          chk_bit(lane_sol, nword == 0);
          chk_bit(lane_sof, nword == 0 && row_read_addr == 12'h008);
        end
        for (int k = 0; k < 4; k++) sh[k] = {sh[k][8:0], lane_bit[k]};
        nbit++;
        if (nbit == 10) begin
          for (int k = 0; k < 4; k++) chk(sh[k], expw(row_read_addr, sample_grp, k));
          if (nword == 0) first_grp = sample_grp;
          last_grp = sample_grp;
          nword++;
          nbit = 0;
        end
      end else begin
        chk(lane_bit, 16'h0000);
      end
    end
  end

  task automatic t_reset;
    reset = 1'b1;
    repeat (8) tick();
    reset = 1'b0;
    tick();
    chk_bit(frame_busy, 1'b0);
    chk_bit(flash_out, 1'b0);
    chk(frame_count, 16'h0000);
    for (int c = 0; c < 4; c++) chk(black_level[c], 16'h0000);
    mon_on = 1'b1;
  endtask

  // The exposure change after the start must not move reads off the latched gap.
  task automatic t_start;
    stream_on = 1'b1;
    tick();
    chk_bit(frame_busy, 1'b1);
    chk_bit(row_reset_pulse, 1'b1);
    chk(row_reset_addr, 16'h0000);
    chk_bit(row_read_pulse, 1'b0);
    exposure_rows = 12'h005;
    tick();
    chk_bit(row_reset_pulse, 1'b0);
  endtask

  task automatic t_dark;
    bit seen;
    seen = 1'b0;
    slow = 1'b1;
    for (int i = 0; i < 40000 && !(row_read_pulse && row_read_addr == 12'h008); i++) begin
      if (row_reset_pulse && row_reset_addr == 12'h008 && !seen) begin
        seen = 1'b1;
        chk_bit(flash_out, 1'b0);
        tick();
        chk_bit(flash_out, 1'b1);
      end
      tick();
    end
    for (int c = 0; c < 4; c++) chk(black_level[c], 16'(64 + 16 * c));
    chk_bit(seen, 1'b1);
    slow = 1'b0;
  endtask

  task automatic t_row8;
    tick();
    for (int i = 0; i < 12000 && !(row_read_pulse && row_read_addr == 12'h009); i++) tick();
    tick();
    chk(16'(row_words), 16'd816);
    chk(16'(first_grp), 16'd2);
    chk(16'(last_grp), 16'd817);
    chk(frame_count, 16'h0000);
    chk_bit(frame_busy, 1'b1);
  endtask

  task automatic t_flash_off;
    flash_enable = 1'b0;
    tick();
    chk_bit(flash_out, 1'b0);
  endtask

  initial begin
    reset = 1'b1;
    stream_on = 1'b0;
    flash_enable = 1'b1;
    slow = 1'b0;
    exposure_rows = 12'(EXP);
    colour_gain = {8'h10, 8'h30, 8'h80, 8'h20};
    colour_pedestal = {10'h040, 10'h030, 10'h020, 10'h010};
    t_reset();
    t_start();
    t_dark();
    t_row8();
    t_flash_off();
    finish_test();
  end
endmodule
